// *** core/pin_mux_pkg.sv ***
// Purpose: Shared constants for the port pin function multiplexer.
// Assumes: 18 pins packed as {port2[1:0], port1[7:0], port0[7:0]}.
// Notes: Byte addresses of the register window, modes and pin slots.
package pin_mux_pkg;
    // ************************************************
    // Register map (byte addresses)
    // ************************************************
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] LATCH0_ADDR = 8'h04;
    localparam logic [7:0] LATCH1_ADDR = 8'h08;
    localparam logic [7:0] LATCH2_ADDR = 8'h0C;
    localparam logic [7:0] MODE0_ADDR = 8'h10;
    localparam logic [7:0] MODE1_ADDR = 8'h14;
    localparam logic [7:0] MODE2_ADDR = 8'h18;
    localparam logic [7:0] STAT_ADDR = 8'h1C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Control register bits
    localparam int DIVIDED_CLOCK_OUTPUT_EN_BIT = 0;
    localparam int TX_EN_BIT = 1;
    localparam int T0_OUT_BIT = 2;
    localparam int T1_OUT_BIT = 3;
    localparam int COMPARATOR_ONE_OUTPUT_OUT_BIT = 4;
    localparam int COMPARATOR_TWO_OUTPUT_OUT_BIT = 5;
    localparam int TWI_EN_BIT = 6;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    // ************************************************
    // Configuration byte fields and oscillator options
    // ************************************************
    localparam int CFG_LEVEL_BIT = 0;
    localparam int CFG_RSTPIN_BIT = 1;
    localparam int CFG_OSC_LSB = 2;
    localparam logic [1:0] OSC_RC = 2'h0;
    localparam logic [1:0] OSC_EXT = 2'h1;
    localparam logic [1:0] OSC_XTAL = 2'h2;
    // Output types: quasi, push-pull, open-drain, input-only
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_PP = 2'h1;
    localparam logic [1:0] MODE_OD = 2'h2;
    localparam logic [1:0] MODE_INPUT = 2'h3;
    // ************************************************
    // Pin slots and timing
    // ************************************************
    localparam int NPINS = 18;
    localparam int PIN_COMPARATOR_TWO_OUTPUT = 0;
    localparam int PIN_COMPARATOR_TWO_POSITIVE_B = 1;
    localparam int PIN_COMPARATOR_TWO_POSITIVE_A = 2;
    localparam int PIN_COMPARATOR_ONE_POSITIVE_B = 3;
    localparam int PIN_COMPARATOR_ONE_POSITIVE_A = 4;
    localparam int PIN_CREF = 5;
    localparam int PIN_COMPARATOR_ONE_OUTPUT = 6;
    localparam int PIN_T1 = 7;
    localparam int PIN_TX = 8;
    localparam int PIN_RX = 9;
    localparam int PIN_T0SCL = 10;
    localparam int PIN_I0SDA = 11;
    localparam int PIN_I1 = 12;
    localparam int PIN_RST = 13;
    localparam int PIN_X2 = 16;
    localparam int PIN_X1 = 17;
    localparam int CLK_DIVIDE = 6;
    localparam logic [1:0] CLK_HALF_LAST = 2'(CLK_DIVIDE / 2 - 1);
endpackage

// *** core/port_pin_function_mux.sv ***
// Purpose: Pin function multiplexer for three ports with AXI4-Lite access.
// Assumes: Configuration byte is a static strap; peripherals share core_clk_in.
// Notes: Pin inputs pass three sync flops and a filter flop; pin drives and bus outputs are registered.
`timescale 1ns/1ps
module port_pin_function_mux #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    input wire logic [ADDR_W-1:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    input wire logic [7:0] user_configuration_byte_one_in,
    input wire logic [7:0] port0_in,
    output logic [7:0] port0_out,
    output logic [7:0] port0_oe_out,
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe_out,
    input wire logic [1:0] port2_in,
    output logic [1:0] port2_out,
    output logic [1:0] port2_oe_out,
    input wire logic comparator_one_output_in,
    input wire logic comparator_two_output_in,
    input wire logic timer_zero_pin_toggle_in,
    input wire logic timer_one_pin_toggle_in,
    input wire logic serial_tx_in,
    input wire logic twi_clock_drive_low_in,
    input wire logic twi_data_drive_low_in,
    output logic comparator_one_positive_a_out,
    output logic comparator_one_positive_b_out,
    output logic comparator_two_positive_a_out,
    output logic comparator_two_positive_b_out,
    output logic comparator_negative_reference_out,
    output logic [3:0] analog_channel_out,
    output logic timer_zero_pin_out,
    output logic timer_one_pin_out,
    output logic serial_rx_out,
    output logic twi_clock_level_out,
    output logic twi_data_level_out,
    output logic external_interrupt_zero_out,
    output logic external_interrupt_one_out,
    output logic core_reset_out
);
    localparam int N = pin_mux_pkg::NPINS;

    logic [N-1:0] sync1_r, sync2_r, sync3_r, filt_r;
    logic [N-1:0] latch_r, pin_out_r, pin_oe_r, val_prev_r;
    logic [N-1:0] drv_out_nxt, drv_oe_nxt, val_nxt;
    logic [2*N-1:0] mode_r;
    logic [pin_mux_pkg::CTRL_W-1:0] ctrl_r;
    logic cfg_loaded_r, level_r, rst_pin_en_r, core_reset_r;
    logic [1:0] osc_r;
    logic [1:0] div_cnt_r;
    logic clk_div_r;
    logic pin_rst, init_level, xtal;
    logic [N-1:0] func_en, func_val;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic do_write;
    logic [31:0] rd_data_nxt;
    logic rd_hit_nxt;
    logic [7:0] ar_addr;

    // ************************************************
    // Pin input synchronisers
    // ************************************************
    // Three stages; a bit changes only once stages two and three agree
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync1_r <= '1;
            sync2_r <= '1;
            sync3_r <= '1;
            filt_r <= '1;
        end else begin
            sync1_r <= {port2_in, port1_in, port0_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
        end
    end

    // Input-side peripheral routing straight off the filtered flops
    assign comparator_two_positive_b_out = filt_r[pin_mux_pkg::PIN_COMPARATOR_TWO_POSITIVE_B];
    assign comparator_two_positive_a_out = filt_r[pin_mux_pkg::PIN_COMPARATOR_TWO_POSITIVE_A];
    assign comparator_one_positive_b_out = filt_r[pin_mux_pkg::PIN_COMPARATOR_ONE_POSITIVE_B];
    assign comparator_one_positive_a_out = filt_r[pin_mux_pkg::PIN_COMPARATOR_ONE_POSITIVE_A];
    assign comparator_negative_reference_out = filt_r[pin_mux_pkg::PIN_CREF];
    assign analog_channel_out = filt_r[pin_mux_pkg::PIN_COMPARATOR_ONE_OUTPUT:pin_mux_pkg::PIN_COMPARATOR_ONE_POSITIVE_B];
    assign timer_one_pin_out = filt_r[pin_mux_pkg::PIN_T1];
    assign timer_zero_pin_out = filt_r[pin_mux_pkg::PIN_T0SCL];
    assign serial_rx_out = filt_r[pin_mux_pkg::PIN_RX];
    assign twi_clock_level_out = filt_r[pin_mux_pkg::PIN_T0SCL];
    assign twi_data_level_out = filt_r[pin_mux_pkg::PIN_I0SDA];
    assign external_interrupt_zero_out = filt_r[pin_mux_pkg::PIN_I0SDA];
    assign external_interrupt_one_out = filt_r[pin_mux_pkg::PIN_I1];
    assign core_reset_out = core_reset_r;
    assign {port2_out, port1_out, port0_out} = pin_out_r;
    assign {port2_oe_out, port1_oe_out, port0_oe_out} = pin_oe_r;

    // ************************************************
    // Configuration strap and reset pin
    // ************************************************
    // Pin reset only counts once the strap has enabled it
    assign pin_rst = rst_pin_en_r & ~filt_r[pin_mux_pkg::PIN_RST];
    assign init_level = cfg_loaded_r ? level_r
        : user_configuration_byte_one_in[pin_mux_pkg::CFG_LEVEL_BIT];
    assign xtal = (osc_r == pin_mux_pkg::OSC_XTAL);

    // Strap taken on the first edge after release, never under reset
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_loaded_r <= 1'b0;
            level_r <= 1'b1;
            rst_pin_en_r <= 1'b0;
            osc_r <= pin_mux_pkg::OSC_RC;
        end else if (!cfg_loaded_r) begin
            cfg_loaded_r <= 1'b1;
            level_r <= user_configuration_byte_one_in[pin_mux_pkg::CFG_LEVEL_BIT];
            rst_pin_en_r <= user_configuration_byte_one_in[pin_mux_pkg::CFG_RSTPIN_BIT];
            osc_r <= user_configuration_byte_one_in[pin_mux_pkg::CFG_OSC_LSB+:2];
        end
    end

    // Core held in reset; release restarts fetch at address zero
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            core_reset_r <= 1'b1;
        end else begin
            core_reset_r <= pin_rst | ~cfg_loaded_r;
        end
    end

    // ************************************************
    // AXI4-Lite slave
    // ************************************************
    // Write fires once both address and data are held and no answer pends
    assign do_write = ~axi_awready_out & ~axi_wready_out & ~axi_bvalid_out;

    // Write channels, one write in flight
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            axi_awready_out <= 1'b1;
            axi_wready_out <= 1'b1;
            axi_bvalid_out <= 1'b0;
            axi_bresp_out <= pin_mux_pkg::RESP_OKAY;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            if (axi_awvalid_in && axi_awready_out) begin
                axi_awready_out <= 1'b0;
                aw_addr_r <= 8'(axi_awaddr_in);
            end
            if (axi_wvalid_in && axi_wready_out) begin
                axi_wready_out <= 1'b0;
                w_data_r <= axi_wdata_in;
                w_strb_r <= axi_wstrb_in;
            end
            if (do_write) begin
                axi_bvalid_out <= 1'b1;
                axi_bresp_out <= (aw_addr_r > pin_mux_pkg::STAT_ADDR || aw_addr_r[1:0] != 2'h0)
                    ? pin_mux_pkg::RESP_SLVERR : pin_mux_pkg::RESP_OKAY;
            end else if (axi_bvalid_out && axi_bready_in) begin
                axi_bvalid_out <= 1'b0;
                axi_awready_out <= 1'b1;
                axi_wready_out <= 1'b1;
            end
        end
    end

    // Read decode; status shows the filtered pins and strap fields
    assign ar_addr = 8'(axi_araddr_in);
    always_comb begin
        rd_data_nxt = 32'h0000_0000;
        rd_hit_nxt = 1'b1;
        case (ar_addr)
            pin_mux_pkg::CTRL_ADDR: rd_data_nxt = 32'(ctrl_r);
            pin_mux_pkg::LATCH0_ADDR: rd_data_nxt = 32'(latch_r[7:0]);
            pin_mux_pkg::LATCH1_ADDR: rd_data_nxt = 32'(latch_r[15:8]);
            pin_mux_pkg::LATCH2_ADDR: rd_data_nxt = 32'(latch_r[17:16]);
            pin_mux_pkg::MODE0_ADDR: rd_data_nxt = 32'(mode_r[15:0]);
            pin_mux_pkg::MODE1_ADDR: rd_data_nxt = 32'(mode_r[31:16]);
            pin_mux_pkg::MODE2_ADDR: rd_data_nxt = 32'(mode_r[35:32]);
            pin_mux_pkg::STAT_ADDR: rd_data_nxt = {10'h000, osc_r, rst_pin_en_r, level_r,
                filt_r[17:16], filt_r[15:0]};
            default: rd_hit_nxt = 1'b0;
        endcase
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            axi_arready_out <= 1'b1;
            axi_rvalid_out <= 1'b0;
            axi_rdata_out <= 32'h0000_0000;
            axi_rresp_out <= pin_mux_pkg::RESP_OKAY;
        end else if (axi_arvalid_in && axi_arready_out) begin
            axi_arready_out <= 1'b0;
            axi_rvalid_out <= 1'b1;
            axi_rdata_out <= rd_data_nxt;
            axi_rresp_out <= rd_hit_nxt ? pin_mux_pkg::RESP_OKAY : pin_mux_pkg::RESP_SLVERR;
        end else if (axi_rvalid_out && axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
            axi_arready_out <= 1'b1;
        end
    end

    // ************************************************
    // Software registers
    // ************************************************
    // Latches and types reload on reset; pin reset acts the same way
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            latch_r <= '1;
            mode_r <= '0;
            ctrl_r <= pin_mux_pkg::CTRL_RESET;
        end else if (!cfg_loaded_r || pin_rst) begin
            latch_r <= {N{init_level}};
            mode_r <= '0;
            ctrl_r <= pin_mux_pkg::CTRL_RESET;
        end else if (do_write) begin
            case (aw_addr_r)
                pin_mux_pkg::CTRL_ADDR:
                    if (w_strb_r[0]) ctrl_r <= w_data_r[pin_mux_pkg::CTRL_W-1:0];
                pin_mux_pkg::LATCH0_ADDR: if (w_strb_r[0]) latch_r[7:0] <= w_data_r[7:0];
                pin_mux_pkg::LATCH1_ADDR: if (w_strb_r[0]) latch_r[15:8] <= w_data_r[7:0];
                pin_mux_pkg::LATCH2_ADDR: if (w_strb_r[0]) latch_r[17:16] <= w_data_r[1:0];
                pin_mux_pkg::MODE0_ADDR: begin
                    if (w_strb_r[0]) mode_r[7:0] <= w_data_r[7:0];
                    if (w_strb_r[1]) mode_r[15:8] <= w_data_r[15:8];
                end
                pin_mux_pkg::MODE1_ADDR: begin
                    if (w_strb_r[0]) mode_r[23:16] <= w_data_r[7:0];
                    if (w_strb_r[1]) mode_r[31:24] <= w_data_r[15:8];
                end
                pin_mux_pkg::MODE2_ADDR: if (w_strb_r[0]) mode_r[35:32] <= w_data_r[3:0];
                default: ;
            endcase
        end
    end

    // ************************************************
    // Divided clock output
    // ************************************************
    // Toggles every third edge, so a full period is six core clocks
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt_r <= 2'h0;
            clk_div_r <= 1'b0;
        end else if (div_cnt_r == pin_mux_pkg::CLK_HALF_LAST) begin
            div_cnt_r <= 2'h0;
            clk_div_r <= ~clk_div_r;
        end else begin
            div_cnt_r <= div_cnt_r + 2'h1;
        end
    end

    // ************************************************
    // Output function selection
    // ************************************************
    // Peripheral drives replace the latch only while enabled
    always_comb begin
        func_en = '0;
        func_val = '0;
        func_en[pin_mux_pkg::PIN_COMPARATOR_TWO_OUTPUT] = ctrl_r[pin_mux_pkg::COMPARATOR_TWO_OUTPUT_OUT_BIT];
        func_val[pin_mux_pkg::PIN_COMPARATOR_TWO_OUTPUT] = comparator_two_output_in;
        func_en[pin_mux_pkg::PIN_COMPARATOR_ONE_OUTPUT] = ctrl_r[pin_mux_pkg::COMPARATOR_ONE_OUTPUT_OUT_BIT];
        func_val[pin_mux_pkg::PIN_COMPARATOR_ONE_OUTPUT] = comparator_one_output_in;
        func_en[pin_mux_pkg::PIN_T1] = ctrl_r[pin_mux_pkg::T1_OUT_BIT];
        func_val[pin_mux_pkg::PIN_T1] = timer_one_pin_toggle_in;
        func_en[pin_mux_pkg::PIN_TX] = ctrl_r[pin_mux_pkg::TX_EN_BIT];
        func_val[pin_mux_pkg::PIN_TX] = serial_tx_in;
        func_en[pin_mux_pkg::PIN_T0SCL] = ctrl_r[pin_mux_pkg::T0_OUT_BIT];
        func_val[pin_mux_pkg::PIN_T0SCL] = timer_zero_pin_toggle_in;
        // Bus drive wins over the timer; a low latch still pulls low
        if (ctrl_r[pin_mux_pkg::TWI_EN_BIT]) begin
            func_en[pin_mux_pkg::PIN_T0SCL] = 1'b1;
            func_val[pin_mux_pkg::PIN_T0SCL] = latch_r[pin_mux_pkg::PIN_T0SCL]
                & ~twi_clock_drive_low_in;
            func_en[pin_mux_pkg::PIN_I0SDA] = 1'b1;
            func_val[pin_mux_pkg::PIN_I0SDA] = latch_r[pin_mux_pkg::PIN_I0SDA]
                & ~twi_data_drive_low_in;
        end
        func_en[pin_mux_pkg::PIN_X2] = ctrl_r[pin_mux_pkg::DIVIDED_CLOCK_OUTPUT_EN_BIT] & ~xtal;
        func_val[pin_mux_pkg::PIN_X2] = clk_div_r;
    end

    // Per-pin driver: quasi pins pull high hard for one cycle on a rise
    for (genvar i = 0; i < N; i++) begin : g_pin
        logic [1:0] m;
        logic v;
        always_comb begin
            v = func_en[i] ? func_val[i] : latch_r[i];
            m = mode_r[2*i+:2];
            if (ctrl_r[pin_mux_pkg::TWI_EN_BIT]
                && (i == pin_mux_pkg::PIN_T0SCL || i == pin_mux_pkg::PIN_I0SDA)) begin
                m = pin_mux_pkg::MODE_OD;
            end
            val_nxt[i] = v;
            drv_out_nxt[i] = v;
            drv_oe_nxt[i] = 1'b0;
            case (m)
                pin_mux_pkg::MODE_QUASI: drv_oe_nxt[i] = ~v | ~val_prev_r[i];
                pin_mux_pkg::MODE_PP: drv_oe_nxt[i] = 1'b1;
                pin_mux_pkg::MODE_OD: begin
                    drv_out_nxt[i] = 1'b0;
                    drv_oe_nxt[i] = ~v;
                end
                default: drv_oe_nxt[i] = 1'b0;
            endcase
            if (i == pin_mux_pkg::PIN_RST) begin
                drv_oe_nxt[i] = 1'b0;
            end
            if (xtal && (i == pin_mux_pkg::PIN_X2 || i == pin_mux_pkg::PIN_X1)) begin
                drv_oe_nxt[i] = 1'b0;
            end
        end
    end

    // Registered pin drive; no drive until the strap is known
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_out_r <= '0;
            pin_oe_r <= '0;
            val_prev_r <= '1;
        end else begin
            pin_out_r <= drv_out_nxt;
            pin_oe_r <= cfg_loaded_r ? drv_oe_nxt : '0;
            val_prev_r <= val_nxt;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    latch_reset_level_a: assert property (pin_rst |=> latch_r == {N{level_r}} && mode_r == '0)
        else $error("latches not reloaded on pin reset");
    input_only_a: assert property (mode_r[3:2] == pin_mux_pkg::MODE_INPUT |=> !pin_oe_r[1])
        else $error("input-only pin driven");
    twi_open_drain_a: assert property ($past(ctrl_r[pin_mux_pkg::TWI_EN_BIT]) |->
        !(pin_oe_r[10] && pin_out_r[10]) && !(pin_oe_r[11] && pin_out_r[11]))
        else $error("two-wire pin driven high");
    pin_reset_hold_a: assert property (pin_rst |=> core_reset_r && ctrl_r == '0)
        else $error("pin reset not applied");
    rst_pin_nodrive_a: assert property (!pin_oe_r[pin_mux_pkg::PIN_RST])
        else $error("reset pin driven");
    divided_clock_output_period_a: assert property ($changed(clk_div_r) |->
        ##1 $stable(clk_div_r) ##1 $stable(clk_div_r) ##1 $changed(clk_div_r))
        else $error("divided clock period wrong");
    xtal_release_a: assert property (xtal && cfg_loaded_r |=> !pin_oe_r[16] && !pin_oe_r[17])
        else $error("oscillator pins driven");
    tx_route_a: assert property (ctrl_r[1] && mode_r[17:16] == pin_mux_pkg::MODE_PP
        |=> pin_out_r[8] == $past(serial_tx_in) && pin_oe_r[8])
        else $error("transmit not on its pin");
    int_route_a: assert property ($past(sync2_r[11]) == $past(sync3_r[11])
        |-> external_interrupt_zero_out == $past(sync3_r[11]))
        else $error("interrupt input not filtered");
    latch_return_a: assert property (!ctrl_r[5] && mode_r[1:0] == pin_mux_pkg::MODE_PP
        |=> pin_out_r[0] == $past(latch_r[0]))
        else $error("latch not restored on pin");

    write_cov: cover property (axi_bvalid_out && axi_bready_in);
    read_cov: cover property (axi_rvalid_out && axi_rready_in);
    pin_reset_cov: cover property (pin_rst);
    divided_clock_output_cov: cover property (pin_oe_r[16] && $rose(pin_out_r[16]));
endmodule

// *** test/board_pin_model.sv ***
// Purpose: Board seen from the port pins: drivers, outside levels.
// Assumes: A pin with its driver off shows the level the bench picks.
// Notes: Contention is not modelled; the device driver wins.
`timescale 1ns/1ps
module board_pin_model (
    input wire logic [17:0] pin_drv_in,
    input wire logic [17:0] pin_oe_in,
    input wire logic [17:0] ext_level_in,
    output logic [17:0] pin_level_out
);
    // Released lines follow the outside party, never the last driven value
    always_comb begin
        for (int i = 0; i < 18; i++) begin
            pin_level_out[i] = pin_oe_in[i] ? pin_drv_in[i] : ext_level_in[i];
        end
    end
endmodule

// *** test/port_pin_function_mux_tb.sv ***
// Purpose: Self-checking bench for the pin function multiplexer.
// Assumes: Strap set before reset; all pin checks wait for the sync flops.
// Notes: Register access goes through AXI4-Lite tasks only.
`timescale 1ns/1ps
module port_pin_function_mux_tb;
    logic core_clk_in, nrst_in, axi_awvalid_in, axi_wvalid_in, axi_bready_in, prev_clk;
    logic axi_arvalid_in, axi_rready_in, axi_awready_out, axi_wready_out, axi_bvalid_out;
    logic axi_arready_out, axi_rvalid_out, comparator_one_output_in, comparator_two_output_in;
    logic timer_zero_pin_toggle_in, timer_one_pin_toggle_in, serial_tx_in;
    logic twi_clock_drive_low_in, twi_data_drive_low_in, comparator_one_positive_a_out;
    logic comparator_one_positive_b_out, comparator_two_positive_a_out, core_reset_out;
    logic comparator_two_positive_b_out, comparator_negative_reference_out, timer_zero_pin_out;
    logic timer_one_pin_out, serial_rx_out, twi_clock_level_out, twi_data_level_out;
    logic external_interrupt_zero_out, external_interrupt_one_out;
    logic [7:0] axi_awaddr_in, axi_araddr_in, user_configuration_byte_one_in;
    logic [31:0] axi_wdata_in, axi_rdata_out, rd_data;
    logic [3:0] axi_wstrb_in, analog_channel_out;
    logic [1:0] axi_bresp_out, axi_rresp_out, rd_resp, wr_resp, port2_in, port2_out, port2_oe_out;
    logic [7:0] port0_in, port0_out, port0_oe_out, port1_in, port1_out, port1_oe_out;
    logic [17:0] ext_level, pin_level;
    int n_fail, tests_run, cyc, edges;
    port_pin_function_mux u_port_pin_function_mux (.*);
    board_pin_model u_board_pin_model (.pin_drv_in({port2_out, port1_out, port0_out}),
        .pin_oe_in({port2_oe_out, port1_oe_out, port0_oe_out}),
        .ext_level_in(ext_level), .pin_level_out(pin_level));
    assign {port2_in, port1_in, port0_in} = pin_level;
    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // Hang guard, well above the fewer than 150 cycles the tests need
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        {axi_awvalid_in, axi_wvalid_in, axi_bready_in} <= 3'h7;
        axi_awaddr_in <= a;
        axi_wdata_in <= d;
        do begin
            @(posedge core_clk_in);
            if (axi_awvalid_in && axi_awready_out) axi_awvalid_in <= 1'b0;
            if (axi_wvalid_in && axi_wready_out) axi_wvalid_in <= 1'b0;
        end while (!axi_bvalid_out);
        wr_resp = axi_bresp_out;
        axi_bready_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_in);
        {axi_arvalid_in, axi_rready_in} <= 2'h3;
        axi_araddr_in <= a;
        do begin
            @(posedge core_clk_in);
            if (axi_arvalid_in && axi_arready_out) axi_arvalid_in <= 1'b0;
        end while (!axi_rvalid_out);
        rd_data = axi_rdata_out;
        rd_resp = axi_rresp_out;
        axi_rready_in <= 1'b0;
    endtask
    task automatic restart(input logic [7:0] strap);
        nrst_in <= 1'b0;
        user_configuration_byte_one_in <= strap;
        repeat (6) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {axi_awvalid_in, axi_wvalid_in, axi_bready_in, axi_arvalid_in, axi_rready_in} = 5'h00;
        {axi_awaddr_in, axi_araddr_in, axi_wdata_in} = '0;
        axi_wstrb_in = 4'hF;
        {comparator_one_output_in, comparator_two_output_in, serial_tx_in} = 3'h0;
        {timer_zero_pin_toggle_in, timer_one_pin_toggle_in} = 2'h0;
        {twi_clock_drive_low_in, twi_data_drive_low_in} = 2'h0;
        ext_level = 18'h3FFFF;
        n_fail = 0;
        tests_run = 0;
        cyc = 0;
        restart(8'h01);
        rd(pin_mux_pkg::LATCH0_ADDR); chk(rd_data, 32'hFF);
        rd(pin_mux_pkg::MODE1_ADDR); chk(rd_data, 32'h0);
        chk(port0_out, 8'hFF);
        wr(pin_mux_pkg::MODE1_ADDR, 32'h1);
        repeat (3) @(posedge core_clk_in);
        chk(port1_oe_out, 8'h01);
        wr(pin_mux_pkg::CTRL_ADDR, 32'h2);
        repeat (3) @(posedge core_clk_in);
        chk(port1_out[0], 1'b0);
        wr(pin_mux_pkg::CTRL_ADDR, 32'h0);
        repeat (3) @(posedge core_clk_in);
        chk(port1_out[0], 1'b1);
        // Comparator and timer outputs pull their quasi pins low against latch ones
        wr(pin_mux_pkg::CTRL_ADDR, 32'h3C);
        repeat (3) @(posedge core_clk_in);
        chk({port0_out[7:6], port0_out[0], port1_out[2]}, 4'h0);
        wr(pin_mux_pkg::CTRL_ADDR, 32'h0);
        ext_level <= 18'h3E528; // P0.3, P0.5 high; P0.7, P1.1, P1.3, P1.4 low
        repeat (6) @(posedge core_clk_in);
        chk(analog_channel_out, 4'h5);
        chk({comparator_one_positive_b_out, comparator_one_positive_a_out}, 2'h2);
        chk(comparator_negative_reference_out, 1'b1);
        chk({timer_one_pin_out, serial_rx_out}, 2'h0);
        chk({external_interrupt_zero_out, external_interrupt_one_out}, 2'h0);
        chk({comparator_two_positive_b_out, comparator_two_positive_a_out}, 2'h0);
        chk({timer_zero_pin_out, twi_clock_level_out, twi_data_level_out}, 3'h6);
        wr(pin_mux_pkg::MODE1_ADDR, 32'h5555);
        wr(pin_mux_pkg::CTRL_ADDR, 32'h40);
        twi_clock_drive_low_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        chk({port1_oe_out[2], port1_out[2], port1_oe_out[5]}, 3'h4);
        twi_clock_drive_low_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        chk(port1_oe_out[3:2], 2'h0);
        wr(pin_mux_pkg::MODE2_ADDR, 32'h1);
        wr(pin_mux_pkg::CTRL_ADDR, 32'h1);
        repeat (3) @(posedge core_clk_in);
        edges = 0;
        prev_clk = port2_out[0];
        // Clock divided by six toggles twice per period: four changes in 12 cycles
        repeat (12) begin
            @(posedge core_clk_in);
            if (port2_out[0] !== prev_clk) edges++;
            prev_clk = port2_out[0];
        end
        chk(edges, 32'h4);
        chk({port2_oe_out[0], pin_level[16]}, {1'b1, port2_out[0]});
        rd(8'h20); chk(rd_resp, pin_mux_pkg::RESP_SLVERR);
        wr(8'h20, 32'h0); chk(wr_resp, pin_mux_pkg::RESP_SLVERR);
        restart(8'h0A);
        rd(pin_mux_pkg::LATCH0_ADDR); chk(rd_data, 32'h0);
        wr(pin_mux_pkg::MODE2_ADDR, 32'h5);
        // P0.0 push-pull, P0.1 input-only against a zero latch
        wr(pin_mux_pkg::MODE0_ADDR, 32'hD);
        repeat (3) @(posedge core_clk_in);
        chk({port2_oe_out, core_reset_out, port0_oe_out[1:0]}, 5'h01);
        ext_level[13] <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        chk(core_reset_out, 1'b1);
        tally_and_finish();
    end
endmodule
